// *** shared/cal_status_pkg.sv ***
// Purpose: Shared constants and carriers for calibration status reporting
// Assumes: 40 MHz single clock, synchronous active-high reset
// Notes: Status byte and event bit positions follow the usual 488.2 layout
package cal_status_pkg;
    localparam int ERR_CODE_W = 10;
    localparam int ERR_DEPTH = 16;
    localparam int STB_EAV_BIT = 2;
    localparam int STB_MAV_BIT = 4;
    localparam int STB_ESB_BIT = 5;
    localparam int STB_RQS_BIT = 6;
    localparam int ESR_OPC_BIT = 0;
    localparam int ESR_DDE_BIT = 3;
    localparam logic [7:0] ESE_RESET = 8'h00;
    localparam logic [7:0] SRE_RESET = 8'h00;
    localparam logic [7:0] OPC_ASCII_ONE = 8'h31;
    localparam logic [7:0] ASCII_COMMA = 8'h2c;
    localparam logic [ERR_CODE_W-1:0] ERR_NONE = 10'h000;
    // Calibration fault codes reported by this block
    localparam logic [ERR_CODE_W-1:0] ERR_ADC_10M_ZERO = 10'h1a5;
    localparam logic [ERR_CODE_W-1:0] ERR_ADC_100M_ZERO = 10'h1a6;
    localparam logic [ERR_CODE_W-1:0] ERR_ADC_10M_FS = 10'h1a7;
    localparam logic [ERR_CODE_W-1:0] ERR_ADC_100M_FS = 10'h1a8;
    localparam logic [ERR_CODE_W-1:0] ERR_ADC_1_FS = 10'h1a9;
    localparam logic [ERR_CODE_W-1:0] ERR_DATE_UNSET = 10'h1b6;
    localparam logic [ERR_CODE_W-1:0] ERR_DUE_UNSET = 10'h1b7;
    localparam logic [ERR_CODE_W-1:0] ERR_POST_FILT = 10'h1d3;
    localparam logic [ERR_CODE_W-1:0] ERR_CARD_COLD = 10'h1dc;
    localparam logic [ERR_CODE_W-1:0] ERR_AOUT_ZERO = 10'h1dd;
    localparam logic [ERR_CODE_W-1:0] ERR_AOUT_POS = 10'h1de;
    localparam logic [ERR_CODE_W-1:0] ERR_AOUT_NEG = 10'h1df;
    localparam logic [ERR_CODE_W-1:0] ERR_DATA_INVALID = 10'h1f4;
    localparam logic [ERR_CODE_W-1:0] ERR_AC_LOST = 10'h1f5;
    localparam logic [ERR_CODE_W-1:0] ERR_DC_LOST = 10'h1f6;
    localparam logic [ERR_CODE_W-1:0] ERR_DATES_LOST = 10'h1f7;

    typedef enum logic [2:0] {
        CMD_NONE = 3'b000,
        CMD_CLS = 3'b001,
        CMD_ESE = 3'b010,
        CMD_SRE = 3'b011,
        CMD_OPC = 3'b100,
        CMD_OPC_QUERY = 3'b101
    } cmd_t;

    typedef struct packed {
        cmd_t op;
        logic [7:0] value;
    } cmd_req_t;

    typedef struct packed {
        logic [ERR_CODE_W-1:0] code;
        logic [7:0] sep;
    } err_resp_t;
endpackage

// *** hdl/cal_error_status_reporting.sv ***
// Purpose: Error queue, status byte, event registers and service request
// Assumes: Command decode upstream gives one-cycle strobes on i_clock
// Notes: Query answers are registered on the edge that takes the strobe
`timescale 1ns/100ps
module cal_error_status_reporting #(
    parameter int DEPTH = cal_status_pkg::ERR_DEPTH
) (
    input wire logic i_clock,
    input wire logic i_srst,
    input wire cal_status_pkg::cmd_req_t i_cmd,
    input wire logic i_step_busy,
    input wire logic [15:0] i_fault,
    input wire logic i_err_query,
    output cal_status_pkg::err_resp_t o_err_resp,
    input wire logic i_esr_query,
    output logic [7:0] o_esr_data,
    input wire logic i_stb_query,
    input wire logic i_serial_poll,
    output logic [7:0] o_stb_data,
    input wire logic i_out_read,
    output logic [7:0] o_out_data,
    output logic o_srq,
    output logic o_err_overflow
);
    import cal_status_pkg::*;

    // Pointers wrap on their own, so the depth must be a power of two
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_depth_check
        $error("DEPTH must be a power of two, at least 2");
    end

    localparam int AW = $clog2(DEPTH);

    // Fault code table, one code per fault input bit
    localparam logic [ERR_CODE_W-1:0] CODE_TABLE [16] = '{
        ERR_ADC_10M_ZERO,
        ERR_ADC_100M_ZERO,
        ERR_ADC_10M_FS,
        ERR_ADC_100M_FS,
        ERR_ADC_1_FS,
        ERR_DATE_UNSET,
        ERR_DUE_UNSET,
        ERR_POST_FILT,
        ERR_CARD_COLD,
        ERR_AOUT_ZERO,
        ERR_AOUT_POS,
        ERR_AOUT_NEG,
        ERR_DATA_INVALID,
        ERR_AC_LOST,
        ERR_DC_LOST,
        ERR_DATES_LOST
    };

    logic [ERR_CODE_W-1:0] queue_mem [DEPTH];
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] wr_ptr_nxt;
    logic [AW-1:0] rd_ptr_r;
    logic [AW-1:0] rd_ptr_nxt;
    logic [AW:0] count_r;
    logic [AW:0] count_nxt;
    logic [15:0] pend_r;
    logic [15:0] pend_nxt;
    logic ovf_r;
    logic ovf_nxt;
    logic [7:0] esr_r;
    logic [7:0] esr_nxt;
    logic [7:0] ese_r;
    logic [7:0] ese_nxt;
    logic [7:0] sre_r;
    logic [7:0] sre_nxt;
    logic opc_arm_r;
    logic opc_arm_nxt;
    logic opcq_arm_r;
    logic opcq_arm_nxt;
    logic mav_r;
    logic mav_nxt;
    logic [7:0] out_r;
    logic [7:0] out_nxt;
    err_resp_t err_resp_r;
    err_resp_t err_resp_nxt;
    logic [7:0] esr_data_r;
    logic [7:0] esr_data_nxt;
    logic [7:0] stb_data_r;
    logic [7:0] stb_data_nxt;

    logic [3:0] pick;
    logic push;
    logic pop;
    logic cls;
    logic eav;
    logic esb;
    logic mss;
    logic [7:0] stb_now;

    // Lowest pending fault is queued first; one enters per cycle
    always_comb begin
        pick = 4'h0;
        for (int i = 15; i >= 0; i--) begin
            if (pend_r[i]) begin
                pick = 4'(i);
            end
        end
    end

    assign cls = (i_cmd.op == CMD_CLS);
    assign eav = (count_r != '0);
    assign esb = |(esr_r & ese_r);
    assign pop = i_err_query && eav && !cls;
    assign push = (|pend_r) && !cls && (count_r != (AW+1)'(DEPTH) || pop);

    // Summary bits of the status byte; the request bit is added where read
    always_comb begin
        stb_now = 8'h00;
        stb_now[STB_EAV_BIT] = eav;
        stb_now[STB_MAV_BIT] = mav_r;
        stb_now[STB_ESB_BIT] = esb;
    end
    assign mss = |(stb_now & sre_r);

    // Clear-status beats any push or pop in the same cycle
    always_comb begin
        wr_ptr_nxt = wr_ptr_r;
        rd_ptr_nxt = rd_ptr_r;
        count_nxt = count_r;
        pend_nxt = pend_r | i_fault;
        ovf_nxt = ovf_r;
        if (cls) begin
            wr_ptr_nxt = '0;
            rd_ptr_nxt = '0;
            count_nxt = '0;
            pend_nxt = 16'h0000;
            ovf_nxt = 1'b0;
        end else begin
            if (push) begin
                wr_ptr_nxt = wr_ptr_r + 1'b1;
                pend_nxt[pick] = i_fault[pick];
            end else if (|pend_r && count_r == (AW+1)'(DEPTH)) begin
                ovf_nxt = 1'b1;
                pend_nxt[pick] = i_fault[pick];
            end
            if (pop) begin
                rd_ptr_nxt = rd_ptr_r + 1'b1;
            end
            count_nxt = count_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
            pend_r <= 16'h0000;
            ovf_r <= 1'b0;
        end else begin
            wr_ptr_r <= wr_ptr_nxt;
            rd_ptr_r <= rd_ptr_nxt;
            count_r <= count_nxt;
            pend_r <= pend_nxt;
            ovf_r <= ovf_nxt;
        end
    end

    // Storage has no reset; only entries below the count are read
    always_ff @(posedge i_clock) begin
        if (push) begin
            queue_mem[wr_ptr_r] <= CODE_TABLE[pick];
        end
    end

    // Event, enable, completion and output queue state
    always_comb begin
        esr_nxt = esr_r;
        ese_nxt = ese_r;
        sre_nxt = sre_r;
        opc_arm_nxt = opc_arm_r;
        opcq_arm_nxt = opcq_arm_r;
        mav_nxt = mav_r;
        out_nxt = out_r;
        if (i_esr_query) begin
            esr_nxt = 8'h00;
        end
        if (i_out_read) begin
            mav_nxt = 1'b0;
        end
        unique case (i_cmd.op)
            CMD_ESE: begin
                ese_nxt = i_cmd.value;
            end
            CMD_SRE: begin
                sre_nxt = i_cmd.value;
            end
            CMD_OPC: begin
                opc_arm_nxt = 1'b1;
            end
            CMD_OPC_QUERY: begin
                opcq_arm_nxt = 1'b1;
            end
            CMD_CLS: begin
                esr_nxt = 8'h00;
                opc_arm_nxt = 1'b0;
                opcq_arm_nxt = 1'b0;
            end
            default: begin
            end
        endcase
        // Completion is seen once the step is idle; set wins over a query clear, clear-status wins over set
        if (opc_arm_r && !i_step_busy && !cls) begin
            esr_nxt[ESR_OPC_BIT] = 1'b1;
            opc_arm_nxt = 1'b0;
        end
        if (opcq_arm_r && !i_step_busy && !cls) begin
            out_nxt = OPC_ASCII_ONE;
            mav_nxt = 1'b1;
            opcq_arm_nxt = 1'b0;
        end
        if (push) begin
            esr_nxt[ESR_DDE_BIT] = 1'b1;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            esr_r <= 8'h00;
            ese_r <= ESE_RESET;
            sre_r <= SRE_RESET;
            opc_arm_r <= 1'b0;
            opcq_arm_r <= 1'b0;
            mav_r <= 1'b0;
            out_r <= 8'h00;
        end else begin
            esr_r <= esr_nxt;
            ese_r <= ese_nxt;
            sre_r <= sre_nxt;
            opc_arm_r <= opc_arm_nxt;
            opcq_arm_r <= opcq_arm_nxt;
            mav_r <= mav_nxt;
            out_r <= out_nxt;
        end
    end

    // Registered query answers
    always_comb begin
        err_resp_nxt = err_resp_r;
        esr_data_nxt = esr_data_r;
        stb_data_nxt = stb_data_r;
        if (i_err_query) begin
            err_resp_nxt.code = eav ? queue_mem[rd_ptr_r] : ERR_NONE;
            err_resp_nxt.sep = ASCII_COMMA;
        end
        if (i_esr_query) begin
            esr_data_nxt = esr_r;
        end
        // Status query and serial poll share one answer register
        if (i_stb_query || i_serial_poll) begin
            stb_data_nxt = stb_now;
            stb_data_nxt[STB_RQS_BIT] = mss;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            err_resp_r <= '{code: ERR_NONE, sep: ASCII_COMMA};
            esr_data_r <= 8'h00;
            stb_data_r <= 8'h00;
        end else begin
            err_resp_r <= err_resp_nxt;
            esr_data_r <= esr_data_nxt;
            stb_data_r <= stb_data_nxt;
        end
    end

    assign o_err_resp = err_resp_r;
    assign o_esr_data = esr_data_r;
    assign o_stb_data = stb_data_r;
    assign o_out_data = out_r;
    assign o_srq = mss;
    assign o_err_overflow = ovf_r;
endmodule

// *** sim/cal_error_status_reporting_asserts.sv ***
// Purpose: Port checks for status reporting
// Assumes: One clock, synchronous reset
// Notes: Enables and completion arming tracked from commands
`timescale 1ns/100ps
module cal_status_checker (
    input wire logic i_clock,
    input wire logic i_srst,
    input wire cal_status_pkg::cmd_req_t i_cmd,
    input wire logic i_step_busy,
    input wire logic [15:0] i_fault,
    input wire logic i_esr_query,
    input wire logic i_out_read,
    input wire cal_status_pkg::err_resp_t o_err_resp,
    input wire logic [7:0] o_esr_data,
    input wire logic [7:0] o_out_data,
    input wire logic o_srq,
    input wire logic o_err_overflow
);
    import cal_status_pkg::*;
    logic [7:0] sre_r, sre_nxt, ese_r, ese_nxt;
    logic armed_r, armed_nxt;
    logic idle;
    assign idle = i_cmd.op != CMD_CLS;
    always_comb begin
        sre_nxt = (i_cmd.op == CMD_SRE) ? i_cmd.value : sre_r;
        ese_nxt = (i_cmd.op == CMD_ESE) ? i_cmd.value : ese_r;
        armed_nxt = (i_cmd.op == CMD_OPC) || (armed_r && i_step_busy);
        if (!idle) begin
            armed_nxt = 1'b0;
        end
    end
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            sre_r <= SRE_RESET;
            ese_r <= ESE_RESET;
            armed_r <= 1'b0;
        end else begin
            sre_r <= sre_nxt;
            ese_r <= ese_nxt;
            armed_r <= armed_nxt;
        end
    end
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_srst);
    property p_sep; o_err_resp.sep == ASCII_COMMA; endproperty
    a_sep: assert property (p_sep) else $error("bad separator");
    property p_mask; sre_r == 8'h00 |-> !o_srq; endproperty
    a_mask: assert property (p_mask) else $error("request while masked");
    property p_err_srq; sre_r == 8'h04 && i_fault != 16'h0000 && idle |-> ##2 o_srq; endproperty
    a_err_srq: assert property (p_err_srq) else $error("no request on error");
    property p_ovf; !idle |=> !o_err_overflow; endproperty
    a_ovf: assert property (p_ovf) else $error("overflow kept");
    property p_cls; !idle && i_fault == 16'h0000 && $past(i_fault) == 16'h0000 |=> !o_srq;
    endproperty
    a_cls: assert property (p_cls) else $error("request kept");
    property p_hold;
        (i_cmd.op == CMD_OPC_QUERY && i_step_busy) ##1 (i_step_busy && i_out_read)
        |=> o_out_data != OPC_ASCII_ONE;
    endproperty
    a_hold: assert property (p_hold) else $error("early reply");
    property p_done; armed_r && !i_step_busy && ese_r == 8'h01 && sre_r == 8'h20 && idle
        |=> o_srq; endproperty
    a_done: assert property (p_done) else $error("no request on done");
    property p_esr;
        (i_esr_query && !armed_r && i_cmd.op == CMD_NONE && i_fault == 16'h0000
        && $past(i_fault) == 16'h0000 && $past(i_fault, 2) == 16'h0000) ##1 i_esr_query
        |=> o_esr_data == 8'h00;
    endproperty
    a_esr: assert property (p_esr) else $error("event reg kept");
    c_opc: cover property (i_cmd.op == CMD_OPC);
    c_srq: cover property (o_srq);
    c_ovf: cover property (o_err_overflow);
endmodule
bind cal_error_status_reporting cal_status_checker u_cal_status_checker (
    .i_clock(i_clock), .i_srst(i_srst), .i_cmd(i_cmd), .i_step_busy(i_step_busy),
    .i_fault(i_fault), .i_esr_query(i_esr_query), .i_out_read(i_out_read),
    .o_err_resp(o_err_resp), .o_esr_data(o_esr_data), .o_out_data(o_out_data),
    .o_srq(o_srq), .o_err_overflow(o_err_overflow));

// *** sim/host_ctrl_model.sv ***
// Purpose: Bus controller issuing commands and calibration steps
// Assumes: Tasks entered just after a rising edge
// Notes: Step length given in cycles
`timescale 1ns/100ps
module host_ctrl_model (
    input wire logic i_clock,
    output cal_status_pkg::cmd_req_t o_cmd,
    output logic o_step_busy
);
    import cal_status_pkg::*;
    initial begin
        o_cmd = '{CMD_NONE, 8'h00};
        o_step_busy = 1'b0;
    end
    task automatic send(input cmd_t op, input logic [7:0] v);
        o_cmd <= '{op, v};
        @(posedge i_clock);
        o_cmd <= '{CMD_NONE, 8'h00};
        @(posedge i_clock);
    endtask
    task automatic cal_line(input int len, input cmd_t op);
        o_cmd <= '{op, 8'h00};
        o_step_busy <= 1'b1;
        @(posedge i_clock);
        o_cmd <= '{CMD_NONE, 8'h00};
        repeat (len) @(posedge i_clock);
        o_step_busy <= 1'b0;
        @(posedge i_clock);
    endtask
endmodule

// *** sim/tb_cal_error_status_reporting.sv ***
// Purpose: Self-checking bench for status reporting
// Assumes: Queue depth shortened to 4
// Notes: Query results checked from a note queue
`timescale 1ns/100ps
`define CHK(nm, e, s) begin num_checks++; if ((s) !== (e)) begin n_mismatch++; \
    $display("[FAIL] %s expected %h seen %h", nm, e, s); end end
module tb_cal_error_status_reporting;
    import cal_status_pkg::*;
    typedef struct packed {logic [2:0] k; logic [17:0] v;} note_t;
    logic i_clock = 1'b0;
    logic i_srst = 1'b1;
    logic [15:0] fault = 16'h0000;
    logic eq = 1'b0, rq = 1'b0, sq = 1'b0, sp = 1'b0, orq = 1'b0, pend = 1'b0;
    logic busy, srq, ovf;
    logic [7:0] esr, stb, outd;
    cmd_req_t cmd;
    err_resp_t resp;
    note_t notes[$];
    int n_mismatch = 0, num_checks = 0, seed = 32'h02b1;
    logic [9:0] code [16] = '{10'h1a5, 10'h1a6, 10'h1a7, 10'h1a8, 10'h1a9, 10'h1b6,
        10'h1b7, 10'h1d3, 10'h1dc, 10'h1dd, 10'h1de, 10'h1df, 10'h1f4, 10'h1f5, 10'h1f6,
        10'h1f7};
    always #12.5 i_clock = ~i_clock;
    host_ctrl_model u_host_ctrl_model (.i_clock(i_clock), .o_cmd(cmd), .o_step_busy(busy));
    cal_error_status_reporting #(.DEPTH(4)) u_cal_error_status_reporting (
        .i_clock(i_clock), .i_srst(i_srst), .i_cmd(cmd), .i_step_busy(busy),
        .i_fault(fault), .i_err_query(eq), .o_err_resp(resp), .i_esr_query(rq),
        .o_esr_data(esr), .i_stb_query(sq), .i_serial_poll(sp), .o_stb_data(stb),
        .i_out_read(orq), .o_out_data(outd), .o_srq(srq), .o_err_overflow(ovf));
    always @(negedge i_clock) begin
        note_t n;
        logic [17:0] got;
        if (pend) begin
            n = notes.pop_front();
            got = n.k == 3'd0 ? resp : {10'h000, n.k == 3'd1 ? esr : n.k == 3'd3 ? outd : stb};
            `CHK("query", n.v, got)
        end
        pend = eq | rq | sq | sp | orq;
    end
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic ask(input logic [2:0] k, input logic [17:0] v);
        notes.push_back('{k, v});
        {sp, orq, sq, rq, eq} <= 5'h01 << k;
        @(posedge i_clock);
        {sp, orq, sq, rq, eq} <= 5'h00;
        @(posedge i_clock);
    endtask
    task automatic pulse(input logic [15:0] f);
        fault <= f;
        @(posedge i_clock);
        fault <= 16'h0000;
        repeat (20) @(posedge i_clock);
    endtask
    task automatic wait_srq(input logic lvl);
        int t;
        t = 0;
        while (srq !== lvl && t < 60) begin
            @(negedge i_clock);
            t++;
        end
        if (t == 60) begin
            n_mismatch++;
            conclude();
        end
        @(posedge i_clock);
    endtask
    initial begin
        logic [15:0] r;
        int cnt;
        repeat (5) @(posedge i_clock);
        i_srst <= 1'b0;
        @(posedge i_clock);
        ask(3'd2, 18'h00000);
        for (int i = 0; i < 16; i++) begin
            pulse(16'h0001 << i);
            ask(3'd2, 18'h00004);
            ask(3'd1, 18'h00008);
            ask(3'd0, {code[i], ASCII_COMMA});
            ask(3'd4, 18'h00000);
        end
        repeat (2) begin
            r = 16'($random(seed));
            pulse(r);
            cnt = 0;
            for (int b = 0; b < 16; b++) begin
                if (r[b] && cnt < 4) begin
                    ask(3'd0, {code[b], ASCII_COMMA});
                    cnt++;
                end
            end
            ask(3'd0, {ERR_NONE, ASCII_COMMA});
            `CHK("overflow", $countones(r) > 4, ovf)
            u_host_ctrl_model.send(CMD_CLS, 8'h00);
            `CHK("overflow", 1'b0, ovf)
        end
        u_host_ctrl_model.send(CMD_SRE, 8'h04);
        pulse(16'h0080);
        `CHK("srq", 1'b1, srq)
        ask(3'd0, {code[7], ASCII_COMMA});
        u_host_ctrl_model.send(CMD_SRE, 8'h10);
        fork
            u_host_ctrl_model.cal_line(12, CMD_OPC_QUERY);
            begin
                @(posedge i_clock);
                ask(3'd3, 18'h00000);
            end
        join
        wait_srq(1'b1);
        ask(3'd2, 18'h00050);
        ask(3'd3, {10'h000, OPC_ASCII_ONE});
        ask(3'd4, 18'h00000);
        u_host_ctrl_model.send(CMD_ESE, 8'h01);
        u_host_ctrl_model.send(CMD_SRE, 8'h20);
        u_host_ctrl_model.cal_line(10, CMD_OPC);
        wait_srq(1'b1);
        ask(3'd4, 18'h00060);
        notes.push_back('{3'd1, 18'h00009});
        notes.push_back('{3'd1, 18'h00000});
        rq <= 1'b1;
        repeat (2) @(posedge i_clock);
        rq <= 1'b0;
        wait_srq(1'b0);
        pulse(16'h0100);
        u_host_ctrl_model.cal_line(3, CMD_OPC);
        u_host_ctrl_model.send(CMD_CLS, 8'h00);
        ask(3'd1, 18'h00000);
        ask(3'd0, {ERR_NONE, ASCII_COMMA});
        ask(3'd2, 18'h00000);
        conclude();
    end
endmodule
